// File: verilog/three_wire_serial_port_defs.vh
// Constants for the three-wire clocked serial port
// Summary of operation
// - Enable bit clear: no serial transfer happens on any serial line.
// - Stopped port: shift register holds, acts as plain 8-bit storage.
// - Stopped port: data-in, data-out and clock pins return to port use.
// - Mode register at FF60H, reset clears it to 00H, bit 0 always zero.
// - Mode register takes single-bit writes and whole-byte writes.
// - Bit 7 stops the port when 0 and enables it when 1.
// - Clock source bit: 0 external pin clock, 1 internal divided clock.
// - Mode bits pick three-wire with bit order, single-bus, or two-wire; only three-wire mode transfers here.
// - Wakeup bit 0 raises transfer interrupt after every transfer.
// - Three lines only: shift clock, data out, data in.
// - Three-wire mode: data-out push-pull, clock push-pull I/O, data-in input.
// - Bit 6 address-match flag is read-only; writes leave it alone.
// - Clock latch 1 needed for serial clock; latch 0 drives pin low.
// - Transmit-only use leaves data-in pin as ordinary port I/O.
`ifndef THREE_WIRE_SERIAL_PORT_DEFS_VH
`define THREE_WIRE_SERIAL_PORT_DEFS_VH

`define MODE_REG_ADDR     16'hff60
`define SHIFT_REG_ADDR    16'hff1f
`define MODE_REG_RESET    8'h00
`define MODE_WRITE_MASK   8'hbe
`define BIT_ENABLE        7
`define BIT_ADDR_MATCH    6
`define BIT_WAKEUP        5
`define BIT_MODE_HIGH     4
`define BIT_MODE_MID      3
`define BIT_ORDER         2
`define BIT_CLK_SRC       1
`define XFER_BITS         4'h8
`define BUF_DEPTH         2

`endif

// File: verilog/two_entry_buffer.v
// Two-entry valid/ready buffer for received bytes
module two_entry_buffer
(
   // Clock and reset
   input  wire       mclk_i,
   input  wire       rst_i,
   // Fill side
   input  wire       in_valid_i,
   output wire       in_ready_o,
   input  wire [7:0] in_data_i,
   // Drain side
   output wire       out_valid_o,
   input  wire       out_ready_i,
   output wire [7:0] out_data_o
);

   reg  [7:0] mem_q [0:1];
   reg        wr_ptr_q;
   reg        rd_ptr_q;
   reg  [1:0] count_q;
   wire       push;
   wire       pop;

   assign in_ready_o  = (count_q != 2'h2);
   assign out_valid_o = (count_q != 2'h0);
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge mclk_i)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop)
         begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

// File: verilog/three_wire_serial_port.v
// Three-wire clocked serial port with mode register and shift register
`include "three_wire_serial_port_defs.vh"

module three_wire_serial_port
(
   // Clock and reset
   input  wire        mclk_i,
   input  wire        rst_i,
   // Memory-manipulation access
   input  wire [15:0] addr_i,
   input  wire        wr_byte_i,
   input  wire        wr_bit_i,
   input  wire [2:0]  bit_sel_i,
   input  wire [7:0]  wdata_i,
   output reg  [7:0]  rdata_o,
   // Port settings and clock rate
   input  wire [7:0]  port_dir_reg_i,
   input  wire [7:0]  port_latch_reg_i,
   input  wire [3:0]  clock_rate_sel_i,
   input  wire        addr_match_flag_i,
   // Received byte stream
   output wire        rx_valid_o,
   input  wire        rx_ready_i,
   output wire [7:0]  rx_data_o,
   // Events and status
   output reg         transfer_irq_o,
   output wire        busy_o,
   // Shift clock pin
   input  wire        shift_clock_pin_i,
   output reg         shift_clock_pin_o,
   output reg         shift_clock_pin_oe_o,
   // Serial out pin
   output reg         serial_out_pin_o,
   output reg         serial_out_pin_oe_o,
   // Serial in pin
   input  wire        serial_in_pin_i
);

   localparam ST_IDLE  = 1'b0;
   localparam ST_SHIFT = 1'b1;

   reg  [7:0] mode_q;
   reg  [7:0] shreg_q;
   reg        state_q;
   reg  [3:0] bitcnt_q;
   reg  [3:0] half_cnt_q;
   reg [15:0] div_q;
   reg        int_clk_q;
   reg        rx_push_q;
   reg  [7:0] rx_byte_q;
   reg  [1:0] sck_sync_q;
   reg  [1:0] sin_sync_q;
   reg        sck_prev_q;
   reg        sin_q;
   reg  [7:0] mode_d;
   wire       enabled;
   wire       three_wire;
   wire       lsb_first;
   wire       int_clk_sel;
   wire       sclk_now;
   wire       rise;
   wire       fall;
   wire       tick;
   wire       buf_ready;
   wire       wr_shreg;
   wire       in_pin_dir_bit;
   wire       out_pin_dir_bit;
   wire       clk_pin_dir_bit;
   wire       out_pin_latch;
   wire       clk_pin_latch;

   assign in_pin_dir_bit  = port_dir_reg_i[5];
   assign out_pin_dir_bit = port_dir_reg_i[6];
   assign clk_pin_dir_bit = port_dir_reg_i[7];
   assign out_pin_latch   = port_latch_reg_i[6];
   assign clk_pin_latch   = port_latch_reg_i[7];

   assign enabled     = mode_q[`BIT_ENABLE];
   assign three_wire  = ~mode_q[`BIT_MODE_HIGH];
   assign lsb_first   = mode_q[`BIT_ORDER];
   assign int_clk_sel = mode_q[`BIT_CLK_SRC];
   assign busy_o      = (state_q == ST_SHIFT);
   assign wr_shreg    = wr_byte_i & (addr_i == `SHIFT_REG_ADDR);

   // Pin synchronisers
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         sck_sync_q <= 2'b11;
         sin_sync_q <= 2'b00;
         sck_prev_q <= 1'b1;
      end
      else
      begin
         sck_sync_q <= {sck_sync_q[0], shift_clock_pin_i};
         sin_sync_q <= {sin_sync_q[0], serial_in_pin_i};
         sck_prev_q <= sclk_now;
      end
   end

   // Internal clock divider: half period of 2^(rate+1) cycles
   always @(posedge mclk_i)
   begin
      if (rst_i | (state_q == ST_IDLE))
      begin
         div_q <= 16'h0000;
      end
      else if (tick)
      begin
         div_q <= 16'h0000;
      end
      else
      begin
         div_q <= div_q + 16'h0001;
      end
   end

   assign tick     = (div_q == ((16'h0002 << clock_rate_sel_i) - 16'h0001));
   assign sclk_now = int_clk_sel ? int_clk_q : sck_sync_q[1];
   assign rise     = sclk_now & ~sck_prev_q;
   assign fall     = ~sclk_now & sck_prev_q;

   // Mode register with byte and single-bit writes
   always @*
   begin
      mode_d = mode_q;
      if (wr_byte_i & (addr_i == `MODE_REG_ADDR))
      begin
         mode_d = wdata_i;
      end
      else if (wr_bit_i & (addr_i == `MODE_REG_ADDR))
      begin
         mode_d[bit_sel_i] = wdata_i[0];
      end
      mode_d = mode_d & `MODE_WRITE_MASK;
   end

   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         mode_q <= `MODE_REG_RESET;
      end
      else
      begin
         mode_q <= mode_d;
      end
   end

   // Transfer engine
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state_q          <= ST_IDLE;
         shreg_q          <= 8'h00;
         bitcnt_q         <= 4'h0;
         half_cnt_q       <= 4'h0;
         int_clk_q        <= 1'b1;
         sin_q            <= 1'b0;
         serial_out_pin_o <= 1'b1;
         transfer_irq_o   <= 1'b0;
         rx_push_q        <= 1'b0;
         rx_byte_q        <= 8'h00;
      end
      else
      begin
         transfer_irq_o <= 1'b0;
         if (rx_push_q & buf_ready)
         begin
            rx_push_q <= 1'b0;
         end
         case (state_q)
            ST_IDLE:
            begin
               int_clk_q <= 1'b1;
               if (wr_shreg)
               begin
                  shreg_q <= wdata_i;
                  if (enabled & three_wire & ~rx_push_q)
                  begin
                     state_q          <= ST_SHIFT;
                     bitcnt_q         <= 4'h0;
                     half_cnt_q       <= 4'h0;
                     serial_out_pin_o <= lsb_first ? wdata_i[0] : wdata_i[7];
                  end
               end
            end
            ST_SHIFT:
            begin
               if (~enabled)
               begin
                  state_q   <= ST_IDLE;
                  int_clk_q <= 1'b1;
               end
               else
               begin
                  if (int_clk_sel & tick)
                  begin
                     int_clk_q <= ~int_clk_q;
                  end
                  if (rise)
                  begin
                     sin_q <= sin_sync_q[1];
                     if (bitcnt_q == (`XFER_BITS - 4'h1))
                     begin
                        if (lsb_first)
                        begin
                           shreg_q   <= {sin_sync_q[1], shreg_q[7:1]};
                           rx_byte_q <= {sin_sync_q[1], shreg_q[7:1]};
                        end
                        else
                        begin
                           shreg_q   <= {shreg_q[6:0], sin_sync_q[1]};
                           rx_byte_q <= {shreg_q[6:0], sin_sync_q[1]};
                        end
                        state_q   <= ST_IDLE;
                        rx_push_q <= 1'b1;
                        if (~mode_q[`BIT_WAKEUP])
                        begin
                           transfer_irq_o <= 1'b1;
                        end
                     end
                     else
                     begin
                        bitcnt_q   <= bitcnt_q + 4'h1;
                        half_cnt_q <= 4'h1;
                     end
                  end
                  if (fall & (half_cnt_q == 4'h1))
                  begin
                     half_cnt_q <= 4'h0;
                     if (lsb_first)
                     begin
                        shreg_q          <= {sin_q, shreg_q[7:1]};
                        serial_out_pin_o <= shreg_q[1];
                     end
                     else
                     begin
                        shreg_q          <= {shreg_q[6:0], sin_q};
                        serial_out_pin_o <= shreg_q[6];
                     end
                  end
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Pin function selection
   always @*
   begin
      shift_clock_pin_o    = 1'b0;
      shift_clock_pin_oe_o = 1'b0;
      serial_out_pin_oe_o  = 1'b0;
      if (enabled & three_wire)
      begin
         serial_out_pin_oe_o = ~out_pin_dir_bit & ~out_pin_latch;
         if (~clk_pin_dir_bit)
         begin
            shift_clock_pin_oe_o = int_clk_sel | ~clk_pin_latch;
            shift_clock_pin_o    = clk_pin_latch & int_clk_q;
         end
      end
   end

   // Data-in pin direction stays with the port block when only sending
   wire unused_in_dir = in_pin_dir_bit;

   // Read mux
   always @*
   begin
      rdata_o = 8'h00;
      if (addr_i == `MODE_REG_ADDR)
      begin
         rdata_o = {mode_q[7], addr_match_flag_i, mode_q[5:0]};
      end
      else if (addr_i == `SHIFT_REG_ADDR)
      begin
         rdata_o = shreg_q;
      end
   end

   two_entry_buffer u_rx_buf
   (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_valid_i  (rx_push_q),
      .in_ready_o  (buf_ready),
      .in_data_i   (rx_byte_q),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  (rx_data_o)
   );

endmodule

// File: dv/three_wire_serial_port_props.sv
// Assertion checker for the three-wire serial port
module three_wire_serial_port_props (
   // Clock, reset and access
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic [15:0] addr_i,
   input wire logic        wr_byte_i,
   input wire logic        wr_bit_i,
   input wire logic [2:0]  bit_sel_i,
   input wire logic [7:0]  wdata_i,
   input wire logic [7:0]  rdata_o,
   // Port settings
   input wire logic [7:0]  port_latch_reg_i,
   input wire logic        addr_match_flag_i,
   // Stream, status and pins
   input wire logic        rx_valid_o,
   input wire logic        rx_ready_i,
   input wire logic [7:0]  rx_data_o,
   input wire logic        transfer_irq_o,
   input wire logic        busy_o,
   input wire logic        shift_clock_pin_o,
   input wire logic        shift_clock_pin_oe_o,
   input wire logic        serial_out_pin_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en_q;
   // Shadow of the enable bit, followed through byte and bit writes
   always @(posedge mclk_i)
   begin
      if (rst_i)
         en_q <= 1'b0;
      else if (wr_byte_i && addr_i == 16'hff60)
         en_q <= wdata_i[7];
      else if (wr_bit_i && addr_i == 16'hff60 && bit_sel_i == 3'h7)
         en_q <= wdata_i[0];
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   AST_STOP_PINS: assert property (!en_q |-> !shift_clock_pin_oe_o && !serial_out_pin_oe_o)
      else $error("serial pin driven while stopped");
   AST_STOP_IDLE: assert property (!en_q [*2] |-> !busy_o)
      else $error("transfer while stopped");
   AST_BIT0_ZERO: assert property (addr_i == 16'hff60 |-> !rdata_o[0])
      else $error("mode bit 0 not zero");
   AST_BIT6_FLAG: assert property (addr_i == 16'hff60 |-> rdata_o[6] == addr_match_flag_i)
      else $error("mode bit 6 not the flag");
   AST_IRQ_PULSE: assert property (transfer_irq_o |=> !transfer_irq_o)
      else $error("interrupt longer than one cycle");
   AST_IRQ_DATA: assert property ($rose(transfer_irq_o) |-> ##[0:2] rx_valid_o)
      else $error("interrupt without received byte");
   AST_CLK_LATCH: assert property (shift_clock_pin_oe_o && !port_latch_reg_i[7] |-> !shift_clock_pin_o)
      else $error("clock pin not low with latch clear");
   AST_RX_HOLD: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
      else $error("stalled byte lost or changed");
endmodule

// File: dv/serial_peripheral_model.sv
// Behavioural peripheral on the far end of the three-wire link
module serial_peripheral_model (
   // Link lines
   input  wire logic       rst_i,
   input  wire logic       sclk_i,
   input  wire logic       sout_i,
   output logic            sin_o,
   output logic            clk_o,
   // Bench control
   input  wire logic       lsb_i,
   input  wire logic       go_i,
   input  wire logic [7:0] tx_i,
   output logic [7:0]      rx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   initial
   begin
      sin_o = 1'b0;
      clk_o = 1'b1;
      rx_o = 8'h00;
   end
   // External clock: eight pulses per frame, still between frames, edges kept off the system clock edges
   always @(posedge go_i)
   begin
      #5;
      repeat (8)
      begin
         #80 clk_o = 1'b0;
         #80 clk_o = 1'b1;
      end
   end
   always @(negedge sclk_i)
      if (!rst_i)
         sin_o = lsb_i ? tx_i[n] : tx_i[7 - n];
   always @(posedge sclk_i)
      if (!rst_i)
      begin
         rx_o = lsb_i ? {sout_i, rx_o[7:1]} : {rx_o[6:0], sout_i};
         n = n + 1;
         if (n == 8)
         begin
            n = 0;
            // Released line flips only after the port has had time to sample the last bit
            sin_o <= #100 ~sin_o;
         end
      end
endmodule

// File: dv/three_wire_serial_port_test.sv
// Self-checking bench for the three-wire serial port
`include "three_wire_serial_port_defs.vh"
module three_wire_serial_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i = 0, rst_i = 1, wr_byte_i = 0, wr_bit_i = 0, rx_ready_i = 0, flag = 0, stall = 0;
   logic        rx_valid_o, irq, busy, sck_o, sck_oe, so, so_oe, si, ext_clk, go = 0, lsb = 0;
   logic [15:0] addr_i = 0;
   logic [2:0]  bit_sel_i = 0;
   logic [3:0]  rate = 0;
   logic [7:0]  wdata_i = 0, latch = 8'h80, rdata_o, rx_data_o, tx = 0, prx, d, e;
   logic [31:0] seed = 32'h71d46876;
   logic [7:0]  expq[$];
   int          miscompares = 0, checked = 0, irqs = 0, n;
   always #10 mclk_i = ~mclk_i;
   three_wire_serial_port uut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_byte_i(wr_byte_i),
      .wr_bit_i(wr_bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .port_dir_reg_i(8'h20), .port_latch_reg_i(latch), .clock_rate_sel_i(rate),
      .addr_match_flag_i(flag), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
      .transfer_irq_o(irq), .busy_o(busy), .shift_clock_pin_i(sck_oe === 1'b1 ? sck_o : ext_clk),
      .shift_clock_pin_o(sck_o), .shift_clock_pin_oe_o(sck_oe), .serial_out_pin_o(so),
      .serial_out_pin_oe_o(so_oe), .serial_in_pin_i(si));
   serial_peripheral_model peer (.rst_i(rst_i), .sclk_i(sck_oe === 1'b1 ? sck_o : ext_clk), .sout_i(so),
      .sin_o(si), .clk_o(ext_clk), .lsb_i(lsb), .go_i(go), .tx_i(tx), .rx_o(prx));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] mode_exp(input logic [7:0] w);
      return (w & `MODE_WRITE_MASK) | {1'b0, flag, 6'h00};
   endfunction
   task automatic end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      checked++;
      if (g !== x)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic bitw, input logic [2:0] s);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      bit_sel_i <= s;
      wr_byte_i <= !bitw;
      wr_bit_i <= bitw;
      @(posedge mclk_i);
      wr_byte_i <= 0;
      wr_bit_i <= 0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      @(posedge mclk_i);
      addr_i <= a;
      #1 chk(rdata_o, x);
   endtask
   task automatic wait_cond(input int lim, input bit busy_wait);
      for (int k = 0; busy_wait ? busy !== 1'b0 : expq.size() != 0; k++)
      begin
         if (k == lim)
         begin
            miscompares++;
            end_sim();
         end
         @(posedge mclk_i);
      end
   endtask
   task automatic xfer(input logic [7:0] m, input logic [7:0] v);
      tx = seed[15:8];
      lsb = m[2];
      rate <= {2'b00, seed[1:0]};
      expq.push_back(tx);
      wr(`MODE_REG_ADDR, m, 0, 0);
      wr(`SHIFT_REG_ADDR, v, 0, 0);
      n = irqs;
      go <= !m[1];
      #1 chk({7'h00, busy}, 8'h01);
      chk({6'h00, sck_oe, so_oe}, {6'h00, m[1], 1'b1});
      wait_cond(3000, 1);
      repeat (4) @(posedge mclk_i);
      go <= 0;
      chk(prx, v);
      chk(8'(irqs - n), 8'h01);
      rd(`SHIFT_REG_ADDR, tx);
   endtask
   // Drained side stalls at random; every accepted byte is checked in order
   always @(posedge mclk_i)
   begin
      seed <= xs(seed);
      rx_ready_i <= !stall && seed[3];
      if (irq === 1'b1)
         irqs++;
      if (rx_valid_o === 1'b1 && rx_ready_i && expq.size() != 0)
         chk(rx_data_o, expq.pop_front());
   end
   initial
   begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 0;
      rd(`MODE_REG_ADDR, `MODE_REG_RESET);
      d = seed[7:0];
      wr(`SHIFT_REG_ADDR, d, 0, 0);
      rd(`SHIFT_REG_ADDR, d);
      chk({7'h00, busy}, 8'h00);
      flag <= seed[4];
      wr(`MODE_REG_ADDR, 8'h7f, 0, 0);
      rd(`MODE_REG_ADDR, mode_exp(8'h7f));
      wr(`MODE_REG_ADDR, 8'h00, 0, 0);
      e = 8'h00;
      for (int b = 0; b < 7; b++)
      begin
         wr(`MODE_REG_ADDR, 8'h01, 1, b[2:0]);
         e[b] = 1'b1;
         rd(`MODE_REG_ADDR, mode_exp(e));
      end
      wr(`MODE_REG_ADDR, 8'h00, 1, 3'h5);
      rd(`MODE_REG_ADDR, mode_exp(e & 8'hdf));
      for (int i = 0; i < 8; i++)
         xfer({5'h10, i[1:0], 1'b0}, i == 0 ? 8'h00 : i == 1 ? 8'hff : seed[23:16]);
      // Drain first, then fill both buffer entries and the pending byte so the next start is refused
      wait_cond(100, 0);
      stall <= 1;
      xfer(8'h82, seed[9:2]);
      xfer(8'h86, seed[12:5]);
      xfer(8'h82, seed[14:7]);
      wr(`SHIFT_REG_ADDR, 8'h3c, 0, 0);
      repeat (2) @(posedge mclk_i);
      #1 chk({7'h00, busy}, 8'h00);
      stall <= 0;
      wait_cond(100, 0);
      latch <= 8'h00;
      @(posedge mclk_i);
      #1 chk({6'h00, sck_oe, sck_o}, 8'h02);
      wr(`MODE_REG_ADDR, 8'h00, 0, 0);
      #1 chk({6'h00, sck_oe, so_oe}, 8'h00);
      end_sim();
   end
endmodule
bind three_wire_serial_port three_wire_serial_port_props props (.*);
